// >>> rtl/port_pin_pkg.sv
// Constants and carrier types for the port pin override block.
// Assumes two ports of eight pins and an AXI4-Lite bus with 8-bit addresses.
package port_pin_pkg;
  localparam int PORTS = 2;
  localparam int PINS  = 8;
  localparam int NPIN  = PORTS * PINS;
  localparam int AW    = 8;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_DIR_A  = 6'h00;
  localparam logic [5:0] IDX_LAT_A  = 6'h01;
  localparam logic [5:0] IDX_PIN_A  = 6'h02;
  localparam logic [5:0] IDX_DIR_B  = 6'h03;
  localparam logic [5:0] IDX_LAT_B  = 6'h04;
  localparam logic [5:0] IDX_PIN_B  = 6'h05;
  localparam logic [5:0] IDX_PCR    = 6'h12;
  localparam logic [5:0] IDX_GCTL   = 6'h35;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PCR_PULL_OFF_LSB = 0;
  localparam int PCR_BRK_MAKE_LSB = 4;
  localparam int GCTL_PULL_OFF    = 4;
  localparam int GCTL_BSU     = 5;
  localparam int GCTL_BSO     = 6;
  localparam logic [7:0] PCR_RESET  = 8'h00;
  localparam logic [7:0] GCTL_RESET = 8'h00;
  localparam logic [7:0] PCR_MASK   = 8'h33;
  localparam logic [7:0] GCTL_MASK  = 8'h70;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Override signals from the alternate-function modules, one bit a pin
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPIN-1:0] pullup_ovr_en;
    logic [NPIN-1:0] pullup_ovr_val;
    logic [NPIN-1:0] dir_ovr_en;
    logic [NPIN-1:0] dir_ovr_val;
    logic [NPIN-1:0] outval_ovr_en;
    logic [NPIN-1:0] outval_ovr_val;
    logic [NPIN-1:0] latch_toggle_ovr;
    logic [NPIN-1:0] inen_ovr_en;
    logic [NPIN-1:0] inen_ovr_val;
  } ovr_t;

  // Pad-side signals, one bit a pin
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe_n;
    logic [NPIN-1:0] pullup_en;
  } pad_drive_t;
endpackage

// >>> rtl/port_pin_override_logic.sv
// Port pin override logic with its control registers on AXI4-Lite.
// Assumes override inputs come from logic on clk_i; pad inputs are asynchronous.
//
// Notes on behaviour
// - Pull-up only at dir 0, latch 1, enabled
// - Pull-up override value wins when enabled
// - Driver enable from override or direction bit
// - Override value switches driver regardless of direction
// - Driven level from override value or latch
// - Toggle override inverts the latch bit
// - Input enable from sleep state or override
// - Input override value ignores sleep state
// - Raw input to peripherals is unsynchronised
// - Strobes per port, sleep and pull-off global
// - Global bit 4 disables every pull-up not under override
// - Bits 5:4 enable break-before-make per port
// - Bits 1:0 disable pull-ups per port
// - Break-before-make gap lasts one clock
// - No gap when turning output to input
// - Sleep clamps inputs except enabled interrupts
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module port_pin_override_logic (
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_i,
  // AXI4-Lite slave
  input  wire logic [port_pin_pkg::AW-1:0]           s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [port_pin_pkg::AW-1:0]           s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  // Alternate-function side
  input  wire port_pin_pkg::ovr_t                    ovr_i,
  output logic [port_pin_pkg::NPIN-1:0]              alt_raw_input_o,
  // Sleep controller
  input  wire logic                                  sleep_i,
  input  wire logic [port_pin_pkg::NPIN-1:0]         ext_int_en_i,
  // Pads
  input  wire logic [port_pin_pkg::NPIN-1:0]         pad_in_i,
  output port_pin_pkg::pad_drive_t                   pad_o
);
  localparam int NPIN  = port_pin_pkg::NPIN;
  localparam int PINS  = port_pin_pkg::PINS;
  localparam int PORTS = port_pin_pkg::PORTS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NPIN-1:0] dir_reg, dir_next;
  logic [NPIN-1:0] latch_reg, latch_next;
  logic [NPIN-1:0] hold_reg, hold_next;
  logic [NPIN-1:0] sync1_reg, sync2_reg;
  logic [7:0]      pcr_reg, pcr_next;
  logic [7:0]      gctl_reg, gctl_next;
  logic [5:0]      awidx_reg, awidx_next;
  logic            awv_reg, awv_next;
  logic [7:0]      wdata_reg, wdata_next;
  logic            wv_reg, wv_next;
  logic            bvalid_reg, bvalid_next;
  logic [1:0]      bresp_reg, bresp_next;
  logic            rvalid_reg, rvalid_next;
  logic [7:0]      rdata_reg, rdata_next;
  logic [1:0]      rresp_reg, rresp_next;

  logic [NPIN-1:0] inen;
  logic [NPIN-1:0] latch_eff;
  logic [NPIN-1:0] drv_en;
  logic [PORTS-1:0] port_pull_off;
  logic [PORTS-1:0] port_brk_make;
  logic            do_write;

  // ----------------------------------------------------------------
  // Pin muxing, no clock in these paths
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      port_pull_off[p] = pcr_reg[port_pin_pkg::PCR_PULL_OFF_LSB + p]
                         | gctl_reg[port_pin_pkg::GCTL_PULL_OFF];
      port_brk_make[p] = pcr_reg[port_pin_pkg::PCR_BRK_MAKE_LSB + p];
    end
    for (int i = 0; i < NPIN; i++) begin
      latch_eff[i] = latch_reg[i] ^ ovr_i.latch_toggle_ovr[i];
      if (ovr_i.pullup_ovr_en[i]) begin
        pad_o.pullup_en[i] = ovr_i.pullup_ovr_val[i];
      end else begin
        pad_o.pullup_en[i] = !dir_reg[i] && latch_reg[i] && !port_pull_off[i / PINS];
      end
      if (ovr_i.dir_ovr_en[i]) begin
        drv_en[i] = ovr_i.dir_ovr_val[i];
      end else begin
        drv_en[i] = dir_reg[i] && !hold_reg[i];
      end
      pad_o.oe_n[i] = !drv_en[i];
      pad_o.out[i]  = drv_en[i] && (ovr_i.outval_ovr_en[i] ? ovr_i.outval_ovr_val[i]
                                                          : latch_eff[i]);
      if (ovr_i.inen_ovr_en[i]) begin
        inen[i] = ovr_i.inen_ovr_val[i];
      end else begin
        inen[i] = !sleep_i || ext_int_en_i[i];
      end
    end
  end

  // Clamped input feeds peripherals straight, each peripheral synchronises it
  assign alt_raw_input_o = pad_in_i & inen;

  // ----------------------------------------------------------------
  // Pin read synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= alt_raw_input_o;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake and register file
  // ----------------------------------------------------------------
  assign s_axi_awready = !awv_reg && !bvalid_reg;
  assign s_axi_wready  = !wv_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign do_write      = awv_reg && wv_reg;

  always_comb begin
    logic [5:0] ridx;
    logic [PINS-1:0] wv;
    int pin_idx;
    ridx        = s_axi_araddr[7:2];
    wv          = wdata_reg[PINS-1:0];
    pin_idx     = 0;
    dir_next    = dir_reg;
    latch_next  = latch_reg;
    hold_next   = '0;
    pcr_next    = pcr_reg;
    gctl_next   = gctl_reg;
    awidx_next  = awidx_reg;
    awv_next    = awv_reg;
    wdata_next  = wdata_reg;
    wv_next     = wv_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awidx_next = s_axi_awaddr[7:2];
      awv_next   = 1'b1;
    end
    // Only byte lane 0 carries data; with its strobe low the write stores zero,
    // which keeps a stored strobe out of the write path
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      wv_next    = 1'b1;
    end
    if (do_write) begin
      awv_next    = 1'b0;
      wv_next     = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = port_pin_pkg::RESP_OKAY;
      case (awidx_reg)
        port_pin_pkg::IDX_DIR_A, port_pin_pkg::IDX_DIR_B: begin
          for (int k = 0; k < PINS; k++) begin
            pin_idx = (awidx_reg == port_pin_pkg::IDX_DIR_B) ? PINS + k : k;
            dir_next[pin_idx] = wv[k];
            // Tri-state gap only on a rising direction bit
            hold_next[pin_idx] = port_brk_make[pin_idx / PINS] && wv[k] && !dir_reg[pin_idx];
          end
        end
        port_pin_pkg::IDX_LAT_A: latch_next[PINS-1:0]    = wv;
        port_pin_pkg::IDX_LAT_B: latch_next[NPIN-1:PINS] = wv;
        port_pin_pkg::IDX_PIN_A: latch_next[PINS-1:0]    = latch_reg[PINS-1:0] ^ wv;
        port_pin_pkg::IDX_PIN_B: latch_next[NPIN-1:PINS] = latch_reg[NPIN-1:PINS] ^ wv;
        port_pin_pkg::IDX_PCR:   pcr_next  = wdata_reg & port_pin_pkg::PCR_MASK;
        port_pin_pkg::IDX_GCTL:  gctl_next = wdata_reg & port_pin_pkg::GCTL_MASK;
        default: bresp_next = port_pin_pkg::RESP_DECERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = port_pin_pkg::RESP_OKAY;
      case (ridx)
        port_pin_pkg::IDX_DIR_A: rdata_next = dir_reg[PINS-1:0];
        port_pin_pkg::IDX_DIR_B: rdata_next = dir_reg[NPIN-1:PINS];
        port_pin_pkg::IDX_LAT_A: rdata_next = latch_reg[PINS-1:0];
        port_pin_pkg::IDX_LAT_B: rdata_next = latch_reg[NPIN-1:PINS];
        port_pin_pkg::IDX_PIN_A: rdata_next = sync2_reg[PINS-1:0];
        port_pin_pkg::IDX_PIN_B: rdata_next = sync2_reg[NPIN-1:PINS];
        port_pin_pkg::IDX_PCR:   rdata_next = pcr_reg;
        port_pin_pkg::IDX_GCTL:  rdata_next = gctl_reg;
        default: begin
          rdata_next = 8'h00;
          rresp_next = port_pin_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_reg    <= '0;
      latch_reg  <= '0;
      hold_reg   <= '0;
      pcr_reg    <= port_pin_pkg::PCR_RESET;
      gctl_reg   <= port_pin_pkg::GCTL_RESET;
      awidx_reg  <= 6'h00;
      awv_reg    <= 1'b0;
      wdata_reg  <= 8'h00;
      wv_reg     <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= 2'h0;
    end else begin
      dir_reg    <= dir_next;
      latch_reg  <= latch_next;
      hold_reg   <= hold_next;
      pcr_reg    <= pcr_next;
      gctl_reg   <= gctl_next;
      awidx_reg  <= awidx_next;
      awv_reg    <= awv_next;
      wdata_reg  <= wdata_next;
      wv_reg     <= wv_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks on pin 0 of port A; the global pull-off check covers every pin
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_pullup_ovr: assert property (ovr_i.pullup_ovr_en[0] |-> pad_o.pullup_en[0] == ovr_i.pullup_ovr_val[0])
    else $error("pull-up ignores override");
  a_pullup_cfg: assert property (!ovr_i.pullup_ovr_en[0] && pad_o.pullup_en[0] |->
                                 !dir_reg[0] && latch_reg[0])
    else $error("pull-up on in wrong state");
  a_pullup_exact: assert property (!ovr_i.pullup_ovr_en[0] && !dir_reg[0] && latch_reg[0] &&
                                   !port_pull_off[0] |-> pad_o.pullup_en[0])
    else $error("pull-up missing");
  a_global_pulloff: assert property (gctl_reg[port_pin_pkg::GCTL_PULL_OFF] |->
                                     (pad_o.pullup_en & ~ovr_i.pullup_ovr_en) == '0)
    else $error("pull-up on with global disable");
  a_port_pulloff: assert property (pcr_reg[port_pin_pkg::PCR_PULL_OFF_LSB] && !ovr_i.pullup_ovr_en[0] |->
                                   !pad_o.pullup_en[0])
    else $error("pull-up on with port disable");
  a_dir_ovr: assert property (ovr_i.dir_ovr_en[0] |-> pad_o.oe_n[0] == !ovr_i.dir_ovr_val[0])
    else $error("driver ignores override");
  a_dir_follow: assert property (!ovr_i.dir_ovr_en[0] && !hold_reg[0] |-> pad_o.oe_n[0] == !dir_reg[0])
    else $error("driver does not follow direction");
  a_brk_make_gap: assert property ($rose(dir_reg[0]) && port_brk_make[0] && !ovr_i.dir_ovr_en[0] |->
                                   pad_o.oe_n[0] ##1 (!dir_reg[0] || ovr_i.dir_ovr_en[0] || !pad_o.oe_n[0]))
    else $error("break-before-make gap wrong");
  a_gap_one_clock: assert property (hold_reg[0] |=> !hold_reg[0])
    else $error("gap longer than one clock");
  a_no_gap_off: assert property ($fell(dir_reg[0]) |=> !hold_reg[0])
    else $error("gap on output to input");
  a_inen_ovr: assert property (ovr_i.inen_ovr_en[0] && !ovr_i.inen_ovr_val[0] |-> !alt_raw_input_o[0])
    else $error("input not disabled by override");
  a_inen_awake: assert property (!sleep_i && !ovr_i.inen_ovr_en[0] |-> alt_raw_input_o[0] == pad_in_i[0])
    else $error("input blocked while awake");
  a_sleep_clamp: assert property (sleep_i && !ext_int_en_i[0] && !ovr_i.inen_ovr_en[0] |->
                                  !alt_raw_input_o[0])
    else $error("input not clamped in sleep");
  a_pin_toggle: assert property (do_write && awidx_reg == port_pin_pkg::IDX_PIN_A && wdata_reg[0] |=>
                                 latch_reg[0] != $past(latch_reg[0]))
    else $error("pin write did not toggle latch");
  a_sync_delay: assert property (1'b1 ##2 sync2_reg[0] == $past(alt_raw_input_o[0], 2))
    else $error("pin read delay not two clocks");

  // Driven level and bus answer as seen from outside
  a_drive_value: assert property (!pad_o.oe_n[0] |-> pad_o.out[0] ==
                                  (ovr_i.outval_ovr_en[0] ? ovr_i.outval_ovr_val[0]
                                                          : latch_reg[0] ^ ovr_i.latch_toggle_ovr[0]))
    else $error("driven level wrong");
  a_read_decerr: assert property (s_axi_rvalid && s_axi_rresp == port_pin_pkg::RESP_DECERR |->
                                  s_axi_rdata == 32'h00000000)
    else $error("unmapped read returns data");
endmodule

// >>> verif/alt_func_model.sv
// Model of the alternate-function peripherals beside the port block.
// Assumes the bench hands it override requests on clk_i.
`timescale 1ns/1ps
module alt_func_model (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  // Bench requests and raw pin inputs
  input  wire port_pin_pkg::ovr_t            req_i,
  input  wire logic [port_pin_pkg::NPIN-1:0] raw_i,
  // Toward the block and the bench
  output port_pin_pkg::ovr_t                 ovr_o,
  output logic [port_pin_pkg::NPIN-1:0]      sync_o
);
  logic [port_pin_pkg::NPIN-1:0] meta_reg;
  // Overrides launch from flops, as a real peripheral's would
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovr_o    <= '0;
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      ovr_o    <= req_i;
      meta_reg <= raw_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// >>> verif/tb_port_pin_override_logic.sv
// Self-checking bench for the port pin override block.
// Assumes the package constants and the alternate-function model.
`timescale 1ns/1ps
module tb_port_pin_override_logic;
  localparam logic [7:0] A_PCR = {port_pin_pkg::IDX_PCR, 2'b00};
  localparam logic [7:0] A_GC  = {port_pin_pkg::IDX_GCTL, 2'b00};
  logic        clk_i, reset_i;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        sleep_i = 0;
  logic [15:0] ext_int_en_i = '0, pad_in_i = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata, rd_v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] alt_raw_input_o, sync, oe_b;
  port_pin_pkg::ovr_t       ovr_i, req = '0;
  port_pin_pkg::pad_drive_t pad_o;
  int          fails = 0, tests_run = 0;

  port_pin_override_logic uut (.clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ovr_i, .alt_raw_input_o, .sleep_i, .ext_int_en_i, .pad_in_i,
    .pad_o);
  alt_func_model partner (.clk_i, .reset_i, .req_i(req), .raw_i(alt_raw_input_o), .ovr_o(ovr_i),
    .sync_o(sync));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Write halves are released separately; oe_b keeps the pads seen in the response cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    oe_b = pad_o.oe_n;
    s_axi_bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask

  // The model takes and launches the request on one edge; the second edge is spare
  task automatic set_ovr(input port_pin_pkg::ovr_t v);
    @(posedge clk_i);
    req <= v;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic t_regs();
    chk("oe_n at reset", pad_o.oe_n, 32'h0000FFFF);
    rd(A_PCR);
    chk("pcr reset", rd_v, port_pin_pkg::PCR_RESET);
    rd(A_GC);
    chk("gctl reset", rd_v, port_pin_pkg::GCTL_RESET);
    wr(A_PCR, 8'hFF);
    rd(A_PCR);
    chk("pcr mask", rd_v, 32'h00000033);
    wr(A_GC, 8'hFF);
    rd(A_GC);
    chk("gctl mask", rd_v, 32'h00000070);
    wr(8'hFC, 8'hFF);
    chk("unmapped write", resp, port_pin_pkg::RESP_DECERR);
    rd(8'hFC);
    chk("unmapped read", resp, port_pin_pkg::RESP_DECERR);
    wr(A_PCR, 8'h00);
    wr(A_GC, 8'h00);
  endtask

  task automatic t_pullup();
    wr(8'h04, 8'hFF);
    wr(8'h10, 8'hFF);
    chk("pullup dir0 latch1", pad_o.pullup_en, 32'h0000FFFF);
    wr(8'h00, 8'h0F);
    chk("pullup outputs off", pad_o.pullup_en, 32'h0000FFF0);
    wr(A_PCR, 8'h01);
    chk("port a pullup off", pad_o.pullup_en, 32'h0000FF00);
    wr(A_PCR, 8'h00);
    wr(A_GC, 8'h10);
    chk("global pullup off", pad_o.pullup_en, 32'h00000000);
    set_ovr('{pullup_ovr_en: 16'hFFFF, pullup_ovr_val: 16'h00FF, default: 16'h0000});
    chk("pullup override", pad_o.pullup_en, 32'h000000FF);
    set_ovr('0);
    wr(A_GC, 8'h00);
  endtask

  task automatic t_drive();
    wr(8'h04, 8'h05);
    chk("dir drives", pad_o.oe_n, 32'h0000FFF0);
    chk("latch drives", pad_o.out, 32'h00000005);
    set_ovr('{dir_ovr_en: 16'h00FF, dir_ovr_val: 16'h0033, default: 16'h0000});
    chk("dir override", pad_o.oe_n, 32'h0000FFCC);
    chk("out under dir override", pad_o.out, 32'h00000001);
    set_ovr('{dir_ovr_en: 16'h00FF, dir_ovr_val: 16'h0033, outval_ovr_en: 16'h00FF,
              outval_ovr_val: 16'h00AA, default: 16'h0000});
    chk("value override", pad_o.out, 32'h00000022);
    set_ovr('{dir_ovr_en: 16'h00FF, dir_ovr_val: 16'h0033, latch_toggle_ovr: 16'h00FF,
              default: 16'h0000});
    chk("toggle override", pad_o.out, 32'h00000032);
    set_ovr('0);
  endtask

  task automatic t_input();
    @(posedge clk_i);
    pad_in_i <= 16'hFFFF;
    #1;
    chk("input awake", alt_raw_input_o, 32'h0000FFFF);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    ext_int_en_i <= 16'h0008;
    #1;
    chk("sleep clamp", alt_raw_input_o, 32'h00000008);
    set_ovr('{inen_ovr_en: 16'hFFFF, inen_ovr_val: 16'h00F0, default: 16'h0000});
    chk("input override", alt_raw_input_o, 32'h000000F0);
    set_ovr('0);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    pad_in_i <= 16'h3CA5;
    repeat (3) @(posedge clk_i);
    #1;
    chk("peripheral sync", sync, 32'h00003CA5);
    rd(8'h08);
    chk("pin read a", rd_v, 32'h000000A5);
    rd(8'h14);
    chk("pin read b", rd_v, 32'h0000003C);
  endtask

  task automatic t_bbm();
    wr(8'h00, 8'h00);
    wr(A_PCR, 8'h10);
    wr(8'h00, 8'h01);
    chk("gap cycle", oe_b, 32'h0000FFFF);
    chk("drive after gap", pad_o.oe_n, 32'h0000FFFE);
    wr(8'h0C, 8'h01);
    chk("no gap port b", oe_b, 32'h0000FEFE);
    wr(8'h00, 8'h00);
    chk("no gap to input", oe_b, 32'h0000FEFF);
    wr(A_PCR, 8'h00);
  endtask

  // Pin-register writes toggle only their own port; lane 0 off stores zero
  task automatic t_access();
    wr(8'h04, 8'h3C);
    chk("write okay", resp, port_pin_pkg::RESP_OKAY);
    wr(8'h08, 8'h0F);
    rd(8'h04);
    chk("pin write toggles a", rd_v, 32'h00000033);
    chk("read okay", resp, port_pin_pkg::RESP_OKAY);
    wr(8'h10, 8'h55);
    wr(8'h14, 8'hFF);
    rd(8'h10);
    chk("pin write toggles b", rd_v, 32'h000000AA);
    rd(8'h04);
    chk("port a untouched", rd_v, 32'h00000033);
    wr(8'h0C, 8'h81);
    rd(8'h0C);
    chk("dir b readback", rd_v, 32'h00000081);
    @(posedge clk_i);
    s_axi_wstrb <= 4'hE;
    wr(8'h04, 8'hFF);
    rd(8'h04);
    chk("lane 0 off stores zero", rd_v, 32'h00000000);
    @(posedge clk_i);
    s_axi_wstrb <= 4'hF;
  endtask

  initial begin
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    t_regs();
    t_pullup();
    t_drive();
    t_input();
    t_bbm();
    t_access();
    summarize();
  end

  // Nearly six times the length of the whole sequence
  initial begin
    repeat (1000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule
